// ==== hdl/efcc_controller.sv ====
`timescale 1ns/1ps
module efcc_controller import efcc_pkg::*; #(
	parameter int PRESCALE = PRESCALE_DIV
) (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	// Register port
	input  wire logic [15:0] xfrAddr,
	input  wire logic        xfrWrite,
	input  wire logic        xfrRead,
	input  wire logic [7:0]  xfrWdata,
	output logic      [7:0]  xfrRdata,
	// Flash array
	output efcc_flash_req_s  flashReq,
	input  efcc_flash_rsp_s  flashRsp,
	// CPU and fetch path
	input  wire logic        fetchEccCorr,
	input  wire logic        fetchEccUncorr,
	output logic             cpuHold,
	output logic             eccIrq,
	output logic             eccResetReq
);

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_RUN    = 3'b010,
		ST_VERIFY = 3'b100
	} efcc_state_e;

	efcc_state_e       state_q;
	efcc_state_e       state_d;
	efcc_flash_req_s   req_q;
	efcc_flash_req_s   req_d;
	logic              busy_q;
	logic              busy_d;
	logic              fail_q;
	logic              fail_d;
	logic              verify_q;
	logic              verify_d;
	logic [4:0]        cmd_q;
	logic [4:0]        cmd_d;
	logic [2:0]        tmo_q;
	logic [2:0]        tmo_d;
	logic [7:0]        dataLow_q;
	logic [7:0]        dataLow_d;
	logic [7:0]        dataHigh_q;
	logic [7:0]        dataHigh_d;
	logic [TICK_W-1:0] tickCnt_q;
	logic [TICK_W-1:0] tickCnt_d;
	logic [7:0]        addrLow_q;
	logic [7:0]        addrLow_d;
	logic [7:0]        addrHigh_q;
	logic [7:0]        addrHigh_d;
	logic [7:0]        helper_q;
	logic [7:0]        helper_d;
	logic [7:0]        scaler_q;
	logic [7:0]        scaler_d;
	logic [63:0]       zoneProt_q;
	logic [63:0]       zoneProt_d;
	logic              corrEn_q;
	logic              corrEn_d;
	logic              uncEn_q;
	logic              uncEn_d;
	logic              corrFlag_q;
	logic              corrFlag_d;
	logic              uncFlag_q;
	logic              uncFlag_d;
	logic              rstEn_q;
	logic              rstEn_d;
	logic              irq_q;
	logic              irq_d;
	logic              rstReq_q;
	logic              rstReq_d;
	logic [7:0]        rdata_q;
	logic [7:0]        rdata_d;
	logic              tick;
	logic              cmdWrite;
	logic [4:0]        wcmd;
	logic              cmdLegal;
	efcc_op_e          cmdOp;
	logic [15:0]       addr;
	logic              mainRange;
	logic              ifbRange;
	logic              zoneOpen;
	logic [TICK_W-1:0] tickLimit;
	logic              timedOut;
	efcc_dec_s         dec;
	logic              readCorr;
	logic              readUncorr;

	assign xfrRdata    = rdata_q;
	assign flashReq    = req_q;
	assign cpuHold     = busy_q;
	assign eccIrq      = irq_q;
	assign eccResetReq = rstReq_q;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	efcc_timebase #(
		.PRESCALE (PRESCALE)
	) u_timebase (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.run      (busy_q),
		.scaler   (scaler_q),
		.tick     (tick)
	);

	// ****************************************
	// Command decode
	// ****************************************
	assign addr      = {addrHigh_q, addrLow_q};
	assign cmdWrite  = xfrWrite && (xfrAddr == CMD_ADR);
	assign wcmd      = xfrWdata[4:0];
	assign mainRange = !addr[MAIN_TOP_BIT];
	assign ifbRange  = (addr[15:ZONE_LSB] == '0);
	assign zoneOpen  = zoneProt_q[addr[15:ZONE_LSB]];
	assign dec       = efccDecode(flashRsp.rdata);

	always_comb begin
		cmdLegal = 1'b0;
		cmdOp    = OP_ERASE;
		case (wcmd)
			CMD_MRD: begin
				cmdLegal = mainRange;
				cmdOp    = OP_READ;
			end
			CMD_MWR: begin
				cmdLegal = mainRange && zoneOpen;
				cmdOp    = OP_WRITE;
			end
			CMD_MER: cmdLegal = mainRange && zoneOpen;
			CMD_IRD: begin
				cmdLegal = ifbRange;
				cmdOp    = OP_READ;
			end
			CMD_IWR: begin
				cmdLegal = ifbRange && (addr[IFB_PAGE_BIT]
					|| addr[8:0] >= IFB_WR_MIN);
				cmdOp    = OP_WRITE;
			end
			CMD_IER: cmdLegal = ifbRange && addr[IFB_PAGE_BIT];
			default: cmdLegal = 1'b0;
		endcase
	end

	// The read-back of a write runs against the write count.
	assign tickLimit = (req_q.op == OP_ERASE) ? ERASE_TICKS[tmo_q]
		: WRITE_TICKS[tmo_q];
	assign timedOut  = tick && (tickCnt_q == tickLimit - 14'h0001);

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		state_d    = state_q;
		req_d      = req_q;
		req_d.req  = 1'b0;
		busy_d     = busy_q;
		fail_d     = fail_q;
		verify_d   = verify_q;
		cmd_d      = cmd_q;
		tmo_d      = tmo_q;
		dataLow_d  = dataLow_q;
		dataHigh_d = dataHigh_q;
		tickCnt_d  = tickCnt_q;
		readCorr   = 1'b0;
		readUncorr = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (xfrWrite && xfrAddr == DATA_LOW_ADR) begin
					dataLow_d = xfrWdata;
				end
				if (xfrWrite && xfrAddr == DATA_HIGH_ADR) begin
					dataHigh_d = xfrWdata;
				end
				if (cmdWrite) begin
					cmd_d     = wcmd;
					tmo_d     = xfrWdata[7:TMO_LSB];
					verify_d  = 1'b1;
					fail_d    = !cmdLegal;
					tickCnt_d = '0;
					if (cmdLegal) begin
						busy_d          = 1'b1;
						req_d.req       = 1'b1;
						req_d.op        = cmdOp;
						req_d.infoBlock = (wcmd[4:2] == 3'h0);
						req_d.addr      = addr;
						req_d.wdata     = {dataHigh_q, dataLow_q};
						state_d         = ST_RUN;
					end
				end
			end
			ST_RUN, ST_VERIFY: begin
				if (tick) begin
					tickCnt_d = tickCnt_q + 14'h0001;
				end
				if (timedOut) begin
					fail_d  = 1'b1;
					busy_d  = 1'b0;
					state_d = ST_IDLE;
				end else if (flashRsp.done && state_q == ST_VERIFY) begin
					if (flashRsp.rdata != req_q.wdata) begin
						verify_d = 1'b0;
					end
					busy_d  = 1'b0;
					state_d = ST_IDLE;
				end else if (flashRsp.done && req_q.op == OP_WRITE) begin
					req_d.req = 1'b1;
					req_d.op  = OP_READ;
					state_d   = ST_VERIFY;
				end else if (flashRsp.done) begin
					if (req_q.op == OP_READ) begin
						dataHigh_d = flashRsp.rdata[15:8];
						dataLow_d  = dec.data;
						readCorr   = dec.corr;
						readUncorr = dec.uncorr;
						fail_d     = dec.corr || dec.uncorr;
					end
					busy_d  = 1'b0;
					state_d = ST_IDLE;
				end
			end
			default: begin
				busy_d  = 1'b0;
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_q    <= ST_IDLE;
			req_q      <= '0;
			busy_q     <= CMD_RST[BUSY_BIT];
			fail_q     <= CMD_RST[FAIL_BIT];
			verify_q   <= CMD_RST[VFY_BIT];
			cmd_q      <= CMD_RST[4:0];
			tmo_q      <= CMD_RST[7:TMO_LSB];
			dataLow_q  <= BYTE_RST;
			dataHigh_q <= BYTE_RST;
			tickCnt_q  <= '0;
		end else begin
			state_q    <= state_d;
			req_q      <= req_d;
			busy_q     <= busy_d;
			fail_q     <= fail_d;
			verify_q   <= verify_d;
			cmd_q      <= cmd_d;
			tmo_q      <= tmo_d;
			dataLow_q  <= dataLow_d;
			dataHigh_q <= dataHigh_d;
			tickCnt_q  <= tickCnt_d;
		end
	end

	sequence seqStart;
		state_q == ST_IDLE && cmdWrite && cmdLegal;
	endsequence

	sequence seqReadDone;
		state_q == ST_RUN && req_q.op == OP_READ && flashRsp.done
			&& !timedOut;
	endsequence

	a_start_busy: assert property (
		seqStart |=> busy_q && cpuHold && verify_q && !fail_q)
		else $error("valid command did not start");
	a_bad_code: assert property (
		state_q == ST_IDLE && cmdWrite && !cmdLegal
			|=> fail_q && !busy_q)
		else $error("refused command not failed");
	a_ifb_erase_first: assert property (
		state_q == ST_IDLE && cmdWrite && wcmd == CMD_IER
			&& !addr[IFB_PAGE_BIT] |=> fail_q)
		else $error("erase of first info page allowed");
	a_read_layout: assert property (
		seqReadDone |=> dataHigh_q == $past(flashRsp.rdata[15:8])
			&& !busy_q)
		else $error("read result layout wrong");
	a_read_fail: assert property (
		seqReadDone ##0 (dec.corr || dec.uncorr) |=> fail_q)
		else $error("read check error not failed");
	a_read_flag: assert property (
		seqReadDone ##0 dec.uncorr |=> uncFlag_q)
		else $error("uncorrectable flag not set");
	// A command written in the cycle after the mismatch restores the bit.
	a_verify_clear: assert property (
		state_q == ST_VERIFY && flashRsp.done && !timedOut
			&& flashRsp.rdata != req_q.wdata |=> !verify_q
			##1 (!verify_q || $past(cmdWrite)))
		else $error("verify mismatch not shown");
	a_timeout_bound: assert property (
		busy_q |-> tickCnt_q < tickLimit)
		else $error("command outlived its timeout");
	a_busy_ignore: assert property (
		busy_q && cmdWrite |=> cmd_q == $past(cmd_q))
		else $error("command taken while busy");

	// ****************************************
	// Configuration and read data
	// ****************************************
	always_comb begin
		addrLow_d  = addrLow_q;
		addrHigh_d = addrHigh_q;
		helper_d   = helper_q;
		scaler_d   = scaler_q;
		zoneProt_d = zoneProt_q;
		corrEn_d   = corrEn_q;
		uncEn_d    = uncEn_q;
		corrFlag_d = corrFlag_q;
		uncFlag_d  = uncFlag_q;
		rstEn_d    = rstEn_q;
		rdata_d    = rdata_q;
		if (xfrWrite) begin
			case (xfrAddr)
				ADDR_LOW_ADR:  addrLow_d = xfrWdata;
				ADDR_HIGH_ADR: addrHigh_d = xfrWdata;
				HELPER_ADR:    helper_d = xfrWdata;
				SCALER_ADR:    scaler_d = xfrWdata;
				RESET_CFG_ADR: rstEn_d = xfrWdata[RSTE_BIT];
				FETCH_CFG_ADR: begin
					corrEn_d   = xfrWdata[CEN_BIT];
					uncEn_d    = xfrWdata[UEN_BIT];
					corrFlag_d = corrFlag_q && xfrWdata[CFLG_BIT];
					uncFlag_d  = uncFlag_q && xfrWdata[UFLG_BIT];
				end
				default: begin
					if (xfrAddr[15:PROT_IDX_W] ==
						PROT_BASE_ADR[15:PROT_IDX_W]) begin
						zoneProt_d[xfrAddr[PROT_IDX_W-1:0]*8 +: 8] =
							zoneProt_q[xfrAddr[PROT_IDX_W-1:0]*8 +: 8]
							& xfrWdata;
					end
				end
			endcase
		end
		// A new error wins over a clear in the same cycle.
		corrFlag_d = corrFlag_d || fetchEccCorr || readCorr;
		uncFlag_d  = uncFlag_d || fetchEccUncorr || readUncorr;
		irq_d      = (corrFlag_q && corrEn_q) || (uncFlag_q && uncEn_q);
		rstReq_d   = fetchEccUncorr && rstEn_q;
		if (xfrRead) begin
			case (xfrAddr)
				DATA_LOW_ADR:  rdata_d = dataLow_q;
				DATA_HIGH_ADR: rdata_d = dataHigh_q;
				ADDR_LOW_ADR:  rdata_d = addrLow_q;
				ADDR_HIGH_ADR: rdata_d = addrHigh_q;
				HELPER_ADR:    rdata_d = efccCheckByte(helper_q);
				CMD_ADR:       rdata_d = {verify_q, busy_q, fail_q, cmd_q};
				SCALER_ADR:    rdata_d = scaler_q;
				FETCH_CFG_ADR: rdata_d = {2'h0, uncEn_q, corrEn_q, 2'h0,
					uncFlag_q, corrFlag_q};
				default: begin
					rdata_d = BYTE_RST;
					if (xfrAddr[15:PROT_IDX_W] ==
						PROT_BASE_ADR[15:PROT_IDX_W]) begin
						rdata_d = zoneProt_q[xfrAddr[PROT_IDX_W-1:0]*8 +: 8];
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			addrLow_q  <= BYTE_RST;
			addrHigh_q <= BYTE_RST;
			helper_q   <= BYTE_RST;
			scaler_q   <= SCALER_RST;
			zoneProt_q <= PROT_RST;
			corrEn_q   <= 1'b0;
			uncEn_q    <= 1'b0;
			corrFlag_q <= 1'b0;
			uncFlag_q  <= 1'b0;
			rstEn_q    <= 1'b0;
			irq_q      <= 1'b0;
			rstReq_q   <= 1'b0;
			rdata_q    <= BYTE_RST;
		end else begin
			addrLow_q  <= addrLow_d;
			addrHigh_q <= addrHigh_d;
			helper_q   <= helper_d;
			scaler_q   <= scaler_d;
			zoneProt_q <= zoneProt_d;
			corrEn_q   <= corrEn_d;
			uncEn_q    <= uncEn_d;
			corrFlag_q <= corrFlag_d;
			uncFlag_q  <= uncFlag_d;
			rstEn_q    <= rstEn_d;
			irq_q      <= irq_d;
			rstReq_q   <= rstReq_d;
			rdata_q    <= rdata_d;
		end
	end

	a_zone_sticky: assert property (
		1'b1 |=> (zoneProt_q & ~$past(zoneProt_q)) == '0)
		else $error("protect bit was set by a write");
	a_fetch_reset: assert property (
		fetchEccUncorr && rstEn_q |=> eccResetReq)
		else $error("fetch error reset missing");
	a_helper_code: assert property (
		xfrRead && !xfrWrite && xfrAddr == HELPER_ADR
			|=> xfrRdata == efccCheckByte(helper_q))
		else $error("helper check byte wrong");

endmodule

// ==== hdl/efcc_pkg.sv ====
package efcc_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [15:0] DATA_LOW_ADR  = 16'ha020;
	localparam logic [15:0] DATA_HIGH_ADR = 16'ha021;
	localparam logic [15:0] ADDR_LOW_ADR  = 16'ha022;
	localparam logic [15:0] ADDR_HIGH_ADR = 16'ha023;
	localparam logic [15:0] HELPER_ADR    = 16'ha024;
	localparam logic [15:0] CMD_ADR       = 16'ha025;
	localparam logic [15:0] SCALER_ADR    = 16'ha026;
	localparam logic [15:0] PROT_BASE_ADR = 16'ha030;
	localparam logic [15:0] FETCH_CFG_ADR = 16'ha00d;
	localparam logic [15:0] RESET_CFG_ADR = 16'ha017;
	localparam int          PROT_IDX_W    = 3;

	localparam logic [7:0]  CMD_RST       = 8'h80;
	localparam logic [7:0]  SCALER_RST    = 8'h25;
	localparam logic [7:0]  BYTE_RST      = 8'h00;
	localparam logic [63:0] PROT_RST      = '1;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int VFY_BIT  = 7;
	localparam int BUSY_BIT = 6;
	localparam int FAIL_BIT = 5;
	localparam int TMO_LSB  = 5;
	localparam int UEN_BIT  = 5;
	localparam int CEN_BIT  = 4;
	localparam int UFLG_BIT = 1;
	localparam int CFLG_BIT = 0;
	localparam int RSTE_BIT = 6;

	// ****************************************
	// Command codes and address limits
	// ****************************************
	localparam logic [4:0] CMD_MRD = 5'h10;
	localparam logic [4:0] CMD_MER = 5'h08;
	localparam logic [4:0] CMD_MWR = 5'h04;
	localparam logic [4:0] CMD_IRD = 5'h02;
	localparam logic [4:0] CMD_IWR = 5'h01;
	localparam logic [4:0] CMD_IER = 5'h03;

	localparam int         MAIN_TOP_BIT = 15;
	localparam int         ZONE_LSB     = 10;
	localparam int         IFB_PAGE_BIT = 9;
	localparam logic [8:0] IFB_WR_MIN   = 9'h040;

	// ****************************************
	// Timing
	// ****************************************
	localparam int PRESCALE_DIV = 256;
	localparam int TICK_W       = 14;
	localparam logic [TICK_W-1:0] WRITE_TICKS [8] = '{
		14'h0037, 14'h003c, 14'h0041, 14'h0045,
		14'h004b, 14'h0050, 14'h0055, 14'h0059};
	localparam logic [TICK_W-1:0] ERASE_TICKS [8] = '{
		14'h153b, 14'h1741, 14'h1934, 14'h1af1,
		14'h1cf0, 14'h1ee2, 14'h20d4, 14'h22b9};

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		OP_READ  = 2'h0,
		OP_WRITE = 2'h1,
		OP_ERASE = 2'h2
	} efcc_op_e;

	typedef struct packed {
		logic        req;
		efcc_op_e    op;
		logic        infoBlock;
		logic [15:0] addr;
		logic [15:0] wdata;
	} efcc_flash_req_s;

	typedef struct packed {
		logic        done;
		logic [15:0] rdata;
	} efcc_flash_rsp_s;

	typedef struct packed {
		logic [7:0] data;
		logic       corr;
		logic       uncorr;
	} efcc_dec_s;

	// ****************************************
	// Nibble check code
	// ****************************************
	function automatic logic [3:0] efccCheckNibble(input logic [3:0] d);
		logic p1;
		logic p2;
		logic p3;
		p1 = d[0] ^ d[1] ^ d[3];
		p2 = d[0] ^ d[2] ^ d[3];
		p3 = d[1] ^ d[2] ^ d[3];
		return {^{d, p1, p2, p3}, p3, p2, p1};
	endfunction

	function automatic logic [7:0] efccCheckByte(input logic [7:0] d);
		return {efccCheckNibble(d[7:4]), efccCheckNibble(d[3:0])};
	endfunction

	// Data nibble i is guarded by check nibble i of the high byte.
	function automatic efcc_dec_s efccDecode(input logic [15:0] w);
		efcc_dec_s  r;
		logic [3:0] d;
		logic [3:0] s;
		r = '0;
		for (int i = 0; i < 2; i++) begin
			d = w[i*4 +: 4];
			s = efccCheckNibble(d) ^ w[8+i*4 +: 4];
			if (^{d, w[8+i*4 +: 4]}) begin
				r.corr = 1'b1;
				case (s[2:0])
					3'h3: d[0] = ~d[0];
					3'h5: d[1] = ~d[1];
					3'h6: d[2] = ~d[2];
					3'h7: d[3] = ~d[3];
					default: d = d;
				endcase
			end else if (s[2:0] != 3'h0) begin
				r.uncorr = 1'b1;
			end
			r.data[i*4 +: 4] = d;
		end
		return r;
	endfunction

endpackage

// ==== hdl/efcc_timebase.sv ====
`timescale 1ns/1ps
module efcc_timebase import efcc_pkg::*; #(
	parameter int PRESCALE = PRESCALE_DIV
) (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	// Control
	input  wire logic       run,
	input  wire logic [7:0] scaler,
	// Programming time base
	output logic            tick
);

	localparam int PW = $clog2(PRESCALE);

	logic [PW-1:0] preCnt_q;
	logic [PW-1:0] preCnt_d;
	logic [7:0]    scaleCnt_q;
	logic [7:0]    scaleCnt_d;
	logic          tick_d;

	// Restarting on every command keeps the first period whole.
	always_comb begin
		preCnt_d   = preCnt_q;
		scaleCnt_d = scaleCnt_q;
		tick_d     = 1'b0;
		if (!run) begin
			preCnt_d   = '0;
			scaleCnt_d = 8'h00;
		end else if (preCnt_q == PW'(PRESCALE - 1)) begin
			preCnt_d = '0;
			if (scaleCnt_q == scaler) begin
				scaleCnt_d = 8'h00;
				tick_d     = 1'b1;
			end else begin
				scaleCnt_d = scaleCnt_q + 8'h01;
			end
		end else begin
			preCnt_d = preCnt_q + PW'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			preCnt_q   <= '0;
			scaleCnt_q <= 8'h00;
			tick       <= 1'b0;
		end else begin
			preCnt_q   <= preCnt_d;
			scaleCnt_q <= scaleCnt_d;
			tick       <= tick_d;
		end
	end

endmodule

// ==== sim/efcc_controller_bench.sv ====
`timescale 1ns/1ps
module efcc_controller_bench import efcc_pkg::*; ;
	logic            core_clk = 1'b0;
	logic            sys_rst = 1'b1;
	logic [15:0]     xfrAddr = '0;
	logic            xfrWrite = 1'b0;
	logic            xfrRead = 1'b0;
	logic [7:0]      xfrWdata = '0;
	logic [7:0]      xfrRdata;
	efcc_flash_req_s flashReq;
	efcc_flash_rsp_s flashRsp;
	logic            fetchEccCorr = 1'b0;
	logic            fetchEccUncorr = 1'b0;
	logic            cpuHold;
	logic            eccIrq;
	logic            eccResetReq;
	logic            hang = 1'b0;
	logic            slow = 1'b0;
	logic            flipRead = 1'b0;
	logic            held;
	logic [7:0]      v;
	int              n;
	int              errTotal = 0;
	int              checkCount = 0;
	logic [4:0]      codes [6] = '{CMD_MRD, CMD_MER, CMD_MWR, CMD_IRD,
		CMD_IWR, CMD_IER};
	logic [4:0]      bad [5] = '{5'h00, 5'h05, 5'h12, 5'h1f, 5'h18};
	logic [15:0]     rAdr [9] = '{16'h8000, 16'h003f, 16'h0040, 16'h01ff,
		16'h0040, 16'h0400, 16'h0010, 16'h0400, 16'h0010};
	logic [4:0]      rCmd [9] = '{CMD_MRD, CMD_IWR, CMD_IWR, CMD_IWR,
		CMD_IER, CMD_IWR, CMD_MWR, CMD_MER, CMD_MER};
	logic [8:0]      rFail = 9'h173;

	always #12.5 core_clk = ~core_clk;

	efcc_controller #(.PRESCALE(2)) u_efcc_controller (
		.core_clk(core_clk), .sys_rst(sys_rst), .xfrAddr(xfrAddr),
		.xfrWrite(xfrWrite), .xfrRead(xfrRead), .xfrWdata(xfrWdata),
		.xfrRdata(xfrRdata), .flashReq(flashReq), .flashRsp(flashRsp),
		.fetchEccCorr(fetchEccCorr), .fetchEccUncorr(fetchEccUncorr),
		.cpuHold(cpuHold), .eccIrq(eccIrq), .eccResetReq(eccResetReq));

	efcc_flash_model u_efcc_flash_model (
		.core_clk(core_clk), .sys_rst(sys_rst), .flashReq(flashReq),
		.flashRsp(flashRsp), .hang(hang), .slow(slow),
		.flipRead(flipRead));

	// ************
	// Helpers
	// ************
	function automatic logic [3:0] nib(input logic [3:0] d);
		logic [2:0] p;
		p = {d[1] ^ d[2] ^ d[3], d[0] ^ d[2] ^ d[3], d[0] ^ d[1] ^ d[3]};
		return {^{d, p}, p};
	endfunction

	function automatic logic [7:0] cb(input logic [7:0] d);
		return {nib(d[7:4]), nib(d[3:0])};
	endfunction

	task automatic endOfTest();
		if (errTotal == 0 && checkCount > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		checkCount++;
		if (g !== e) begin
			errTotal++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Every access starts just after an edge and leaves an idle cycle, so
	// a strobe is never lowered and raised in one time step.
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		xfrAddr = a;
		xfrWdata = d;
		xfrWrite = 1'b1;
		@(posedge core_clk);
		#1 xfrWrite = 1'b0;
		@(posedge core_clk);
		#1;
	endtask

	task automatic rc(input logic [15:0] a, input logic [7:0] e,
		input string nm, input logic [7:0] m = 8'hff);
		xfrAddr = a;
		xfrRead = 1'b1;
		@(posedge core_clk);
		#1 xfrRead = 1'b0;
		@(posedge core_clk);
		#1 v = xfrRdata;
		check(nm, e, v & m);
	endtask

	task automatic setup(input logic [15:0] a, input logic [15:0] w);
		wr(ADDR_LOW_ADR, a[7:0]);
		wr(ADDR_HIGH_ADR, a[15:8]);
		wr(DATA_LOW_ADR, w[7:0]);
		wr(DATA_HIGH_ADR, w[15:8]);
	endtask

	task automatic waitIdle();
		n = 0;
		while (cpuHold !== 1'b0) begin
			if (n == 400) begin
				errTotal++;
				$display("BAD idle expected 0 seen %b", cpuHold);
				endOfTest();
			end
			@(posedge core_clk);
			#1 n++;
		end
	endtask

	task automatic cmd(input logic [2:0] sel, input logic [4:0] code);
		wr(CMD_ADR, {sel, code});
		held = cpuHold;
		waitIdle();
	endtask

	initial begin
		repeat (100000) @(posedge core_clk);
		errTotal++;
		$display("BAD run expected end seen hang");
		endOfTest();
	end

	// ************
	// Sequence
	// ************
	initial begin
		repeat (12) @(posedge core_clk);
		#1 sys_rst = 1'b0;
		rc(CMD_ADR, CMD_RST, "status");
		rc(SCALER_ADR, SCALER_RST, "scaler");
		rc(DATA_LOW_ADR, BYTE_RST, "data");
		rc(PROT_BASE_ADR, 8'hff, "protect");
		rc(16'ha040, 8'h00, "unmapped");
		rc(RESET_CFG_ADR, 8'h00, "rstcfg");
		wr(HELPER_ADR, 8'h5a);
		rc(HELPER_ADR, cb(8'h5a), "helper");
		wr(SCALER_ADR, 8'h00);
		slow = 1'b1;
		setup(16'h0123, {cb(8'h3c), 8'h3c});
		cmd(3'h7, CMD_MWR);
		check("hold", 8'h01, {7'h0, held});
		rc(CMD_ADR, 8'h84, "status");
		rc(ADDR_LOW_ADR, 8'h23, "addr");
		rc(ADDR_HIGH_ADR, 8'h01, "addr");
		setup(16'h0123, 16'h0000);
		cmd(3'h7, CMD_MRD);
		rc(CMD_ADR, 8'h90, "status");
		rc(DATA_HIGH_ADR, cb(8'h3c), "data");
		rc(DATA_LOW_ADR, 8'h3c, "data");
		slow = 1'b0;
		wr(FETCH_CFG_ADR, 8'h00);
		for (int k = 0; k < 2; k++) begin
			setup(16'h0124, {cb(8'h3c), 8'h3c ^ {6'h0, k[0], 1'b1}});
			cmd(3'h7, CMD_MWR);
			cmd(3'h7, CMD_MRD);
			rc(CMD_ADR, 8'hb0, "status");
			rc(CMD_ADR, 8'hb0, "status");
			rc(DATA_HIGH_ADR, cb(8'h3c), "raw");
			rc(FETCH_CFG_ADR, {6'h0, k[0], ~k[0]}, "flag");
			if (k == 0) rc(DATA_LOW_ADR, 8'h3c, "fixed");
			wr(FETCH_CFG_ADR, 8'h00);
		end
		flipRead = 1'b1;
		setup(16'h0130, 16'h1234);
		cmd(3'h7, CMD_MWR);
		flipRead = 1'b0;
		rc(CMD_ADR, 8'h00, "verify", 8'h80);
		cmd(3'h7, CMD_MRD);
		rc(CMD_ADR, 8'h80, "verify", 8'h80);
		for (int i = 0; i < 6; i++) begin
			slow = i[0];
			setup(16'h0240, 16'hffff);
			cmd(3'h7, codes[i]);
			check("hold", 8'h01, {7'h0, held});
			rc(CMD_ADR, {3'h4, codes[i]}, "status");
		end
		foreach (bad[i]) begin
			cmd(3'h7, bad[i]);
			check("hold", 8'h00, {7'h0, held});
			rc(CMD_ADR, {3'h5, bad[i]}, "status");
		end
		wr(PROT_BASE_ADR, 8'hfe);
		foreach (rAdr[i]) begin
			setup(rAdr[i], 16'hffff);
			cmd(3'h7, rCmd[i]);
			rc(CMD_ADR, {2'h2, rFail[i], rCmd[i]}, "status");
		end
		wr(PROT_BASE_ADR, 8'hff);
		rc(PROT_BASE_ADR, 8'hfe, "protect");
		// A stalled array shows the hold ends on the timeout alone.
		// The write targets zone one, which is still open.
		setup(16'h0400, 16'hffff);
		wr(SCALER_ADR, 8'h01);
		hang = 1'b1;
		wr(CMD_ADR, {3'h3, CMD_MWR});
		wr(CMD_ADR, {3'h7, CMD_MRD});
		waitIdle();
		check("span", 8'h01, {7'h0, n >= 266 && n <= 286});
		rc(CMD_ADR, 8'ha4, "status");
		hang = 1'b0;
		wr(FETCH_CFG_ADR, 8'h30);
		fetchEccCorr = 1'b1;
		@(posedge core_clk);
		#1 fetchEccCorr = 1'b0;
		@(posedge core_clk);
		#1 check("irq", 8'h01, {7'h0, eccIrq});
		wr(FETCH_CFG_ADR, 8'h20);
		check("irq", 8'h00, {7'h0, eccIrq});
		for (int k = 0; k < 2; k++) begin
			wr(RESET_CFG_ADR, {1'b0, k[0], 6'h0});
			fetchEccUncorr = 1'b1;
			@(posedge core_clk);
			#1 fetchEccUncorr = 1'b0;
			check("reset", {7'h0, k[0]}, {7'h0, eccResetReq});
			@(posedge core_clk);
			#1 check("irq", 8'h01, {7'h0, eccIrq});
		end
		endOfTest();
	end
endmodule

// ==== sim/efcc_flash_model.sv ====
`timescale 1ns/1ps
module efcc_flash_model import efcc_pkg::*; (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	// Array link
	input  efcc_flash_req_s flashReq,
	output efcc_flash_rsp_s flashRsp,
	// Scenario controls
	input  wire logic       hang,
	input  wire logic       slow,
	input  wire logic       flipRead
);
	logic [15:0]     mem [logic [16:0]];
	efcc_flash_req_s cur;
	logic            busy = 1'b0;
	int              cnt = 0;
	logic [16:0]     key;

	assign key = {cur.infoBlock, cur.addr};
	initial flashRsp = '0;

	// Read data toggles outside done, so a stale word never looks valid.
	// An unwritten word reads as erased.
	always @(posedge core_clk) begin
		flashRsp.done <= 1'b0;
		flashRsp.rdata <= ~flashRsp.rdata;
		if (sys_rst) begin
			busy <= 1'b0;
		end else if (flashReq.req && !hang) begin
			busy <= 1'b1;
			cur <= flashReq;
			cnt <= slow ? 20 : 1;
		end else if (busy && cnt > 0) begin
			cnt <= cnt - 1;
		end else if (busy) begin
			busy <= 1'b0;
			flashRsp.done <= 1'b1;
			case (cur.op)
				OP_WRITE: mem[key] = cur.wdata;
				OP_ERASE: for (int i = 0; i < 512; i++) begin
					mem[{cur.infoBlock, cur.addr[15:9], i[8:0]}] = 16'hffff;
				end
				default: flashRsp.rdata <= (mem.exists(key) ? mem[key] :
					16'hffff) ^ {15'h0, flipRead};
			endcase
		end
	end
endmodule
